/* inc/ffc_defines.vh */
// Register offsets, field positions and reset values of the feature control bank
`ifndef FFC_DEFINES_VH
`define FFC_DEFINES_VH
// ==========================================
// Register indices; the bus byte address is four times the index
`define FFC_ADDR_LOOP 8'h26
`define FFC_ADDR_MA 8'h27
`define FFC_ADDR_RXOUT 8'h28
`define FFC_ADDR_EXT 8'h2C
// ==========================================
// Reset values
`define FFC_RST_LOOP 8'h00
`define FFC_RST_MA 8'h00
`define FFC_RST_RXOUT 8'h00
`define FFC_RST_EXT 8'h00
// ==========================================
// Field positions, loopback_feac_control
`define FFC_B_PAYLOAD_LOOP 7
`define FFC_B_LINE_LOOP 6
`define FFC_B_TX_IRQ 5
`define FFC_B_SINGLE 4
`define FFC_B_STACK_IRQ 2
`define FFC_B_IDLE_IRQ 1
`define FFC_B_RX_IRQ 0
// Field positions, ma_byte_field_control
`define FFC_B_SSM_EN 6
`define FFC_B_SSM1 5
`define FFC_B_SSM4 2
`define FFC_B_PD1 1
`define FFC_B_PD2 0
// Field positions, receive_output_control
`define FFC_B_AUTO_ONES 7
`define FFC_B_REFRAME_STOP 6
`define FFC_B_RX_AIS 5
`define FFC_B_RX_ONES 4
`define FFC_B_RX_CLK_INV 1
`define FFC_B_LINE_EDGE 0
// Field positions, extra control (external payload-dependent insertion)
`define FFC_B_EXT_PD 0
// ==========================================
// Frame modes
`define FFC_MODE_DS3 2'd0
`define FFC_MODE_G751 2'd1
`define FFC_MODE_G832 2'd2
// ==========================================
// Quiet time after a write that changes a loopback bit, in clk_sys cycles
`define FFC_LOOP_QUIET 20
`endif

/* logic/ffc_line_sampler.v */
// Line receive sampler: edge detect on the line clock with selectable edge
`timescale 1ns/1ps
`default_nettype none
module ffc_line_sampler (
  input wire clk_sys,
  input wire rst_n,
  input wire lineRxClock,
  input wire lineRxPositive,
  input wire lineRxNegative,
  input wire edgeSelect,
  output reg sampleValid_q,
  output reg samplePos_q,
  output reg sampleNeg_q,
  output reg edgeSeen_q
);
  reg [2:0] clkSync_q;
  reg [1:0] posSync_q;
  reg [1:0] negSync_q;
  wire riseEdge;
  wire fallEdge;
  wire takeSample;
  // ==========================================
  // Two-stage synchronisers; clock gets a third stage for edge detection
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkSync_q <= 3'b000;
      posSync_q <= 2'b00;
      negSync_q <= 2'b00;
    end else begin
      clkSync_q <= {clkSync_q[1:0], lineRxClock};
      posSync_q <= {posSync_q[0], lineRxPositive};
      negSync_q <= {negSync_q[0], lineRxNegative};
    end
  end
  assign riseEdge = clkSync_q[1] & ~clkSync_q[2];
  assign fallEdge = ~clkSync_q[1] & clkSync_q[2];
  // Set selects falling edge, clear selects rising edge
  assign takeSample = edgeSelect ? fallEdge : riseEdge;
  // ==========================================
  // Capture
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sampleValid_q <= 1'b0;
      samplePos_q <= 1'b0;
      sampleNeg_q <= 1'b0;
      edgeSeen_q <= 1'b0;
    end else begin
      sampleValid_q <= takeSample;
      edgeSeen_q <= riseEdge | fallEdge;
      if (takeSample) begin
        samplePos_q <= posSync_q[1];
        sampleNeg_q <= negSync_q[1];
      end
    end
  end
endmodule
`default_nettype wire

/* logic/ffc_feature_ctrl.v */
// Feature control bank 3 to 5: AHB-Lite registers and the receive-side steering
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ffc_defines.vh"
// Behaviour
// - Payload loop bit routes recovered payload into the transmit input.
// - Receive output pins keep carrying data during payload loopback.
// - Loopback changes may drop a few bits while paths switch.
// - MA-byte register acts only in G.832 mode.
// - Sync status enable selects SYNC_STATUS_MSG/MI or TM/PD use of MA bits.
// - MI of 00 sends first sync status bit in bit 8.
// - MI of 01, 10, 11 send second, third, fourth bits.
// - With SYNC_STATUS_MSG off, timing marker goes in bit 8 each frame.
// - With SYNC_STATUS_MSG and external insertion off, PD bits go out every frame.
// - Auto all-ones replaces output data while fault conditions persist.
// - Manual all-ones and AIS outrank automatic all-ones.
// - Receive AIS bit drives AIS pattern on system data output.
// - Receive ones bit drives all ones on system data output.
// - Both manual bits give all ones; detection continues throughout.
// - Reframe stop suppresses frame search regardless of out-of-frame.
// - Clearing reframe stop resumes search one bit forward.
// - Clock invert flips gapped and extraction clocks and gap polarity.
// - Line edge bit selects falling or rising sampling edge.
module ffc_feature_ctrl #(
  parameter LOOP_QUIET = `FFC_LOOP_QUIET
) (
  input wire clk_sys,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Framer status and mode
  input wire [1:0] frameMode,
  input wire outOfFrame,
  input wire lossOfSignal,
  input wire alarmIndication,
  input wire idleDetected,
  input wire [1:0] multiframeIndicator,
  input wire frameStart,
  input wire recoveredValid,
  input wire recoveredData,
  input wire recoveredGap,
  // Alarm-code channel events
  input wire farAlarmTxDone,
  input wire farAlarmTxTenDone,
  input wire farAlarmStackNotEmpty,
  input wire farAlarmIdleStart,
  input wire farAlarmRxCode,
  input wire farAlarmRxTenCode,
  // Line interface unit
  input wire lineRxClock,
  input wire lineRxPositive,
  input wire lineRxNegative,
  // Outputs
  output reg shared_irq_out_n,
  output reg rxSystemDataOut,
  output reg rxGappedClockOut,
  output reg rxExtractClockOut,
  output reg txLoopData,
  output reg txLoopValid,
  output reg txLineLoopPos,
  output reg txLineLoopNeg,
  output reg txLineLoopValid,
  output reg maBit8,
  output reg [1:0] maBits67,
  output reg maBits67Drive,
  output reg frameSearchEn,
  output reg frameSlipOne,
  output reg loopQuiet
);
  // ==========================================
  // Registers
  reg [7:0] loopCtrl_q;
  reg [7:0] maCtrl_q;
  reg [7:0] rxOutCtrl_q;
  reg [7:0] extCtrl_q;
  reg [7:0] addr_q;
  reg wrPend_q;
  reg reframeStopOld_q;
  reg [5:0] quietCnt_q;
  reg [1:0] aisPhase_q;
  reg linePos_q;
  reg lineNeg_q;
  reg lineVal_q;
  wire accept;
  wire samplePos;
  wire sampleNeg;
  wire sampleValid;
  wire decodedBit;
  wire faultAuto;
  wire g832;
  wire irqAny;
  wire singleMode;
  wire wrLoop;
  wire wrMa;
  wire wrRxOut;
  wire wrExt;

  function [7:0] regRead;
    input [7:0] addr;
    input [7:0] r0;
    input [7:0] r1;
    input [7:0] r2;
    input [7:0] r3;
    begin
      case (addr)
        `FFC_ADDR_LOOP: regRead = r0;
        `FFC_ADDR_MA: regRead = r1;
        `FFC_ADDR_RXOUT: regRead = r2;
        `FFC_ADDR_EXT: regRead = r3;
        default: regRead = 8'h00;
      endcase
    end
  endfunction

  // Word-aligned registers: the byte address is four times the index
  function [7:0] regIndex;
    input [7:0] byteAddr;
    begin
      regIndex = {2'b00, byteAddr[7:2]};
    end
  endfunction

  // ==========================================
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accept = hsel & hready & htrans[1];
  // Data-phase write strobes, one per register
  assign wrLoop = wrPend_q & (addr_q == `FFC_ADDR_LOOP);
  assign wrMa = wrPend_q & (addr_q == `FFC_ADDR_MA);
  assign wrRxOut = wrPend_q & (addr_q == `FFC_ADDR_RXOUT);
  assign wrExt = wrPend_q & (addr_q == `FFC_ADDR_EXT);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
      wrPend_q <= 1'b0;
    end else begin
      wrPend_q <= accept & hwrite;
      if (accept) begin
        addr_q <= regIndex(haddr);
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (accept & ~hwrite) begin
      hrdata <= {24'h00_0000,
                 regRead(regIndex(haddr), loopCtrl_q, maCtrl_q, rxOutCtrl_q, extCtrl_q)};
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loopCtrl_q <= `FFC_RST_LOOP;
      maCtrl_q <= `FFC_RST_MA;
      rxOutCtrl_q <= `FFC_RST_RXOUT;
      extCtrl_q <= `FFC_RST_EXT;
    end else begin
      // Reserved bits are never stored, so they read back as zero
      if (wrLoop) begin
        loopCtrl_q <= hwdata[7:0] & 8'hF7;
      end
      if (wrMa) begin
        maCtrl_q <= hwdata[7:0] & 8'h7F;
      end
      if (wrRxOut) begin
        rxOutCtrl_q <= hwdata[7:0] & 8'hFB;
      end
      if (wrExt) begin
        extCtrl_q <= hwdata[7:0] & 8'h01;
      end
    end
  end

  // ==========================================
  // Quiet window after a write that changes a loopback bit; software must not touch the bus
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quietCnt_q <= 6'd0;
      loopQuiet <= 1'b0;
    end else begin
      if (wrLoop && hwdata[7:6] != loopCtrl_q[7:6]) begin
        quietCnt_q <= LOOP_QUIET[5:0];
      end else if (quietCnt_q != 6'd0) begin
        quietCnt_q <= quietCnt_q - 6'd1;
      end
      loopQuiet <= (quietCnt_q != 6'd0);
    end
  end

  // ==========================================
  // Line receive sampling
  ffc_line_sampler ffc_line_sampler_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lineRxClock(lineRxClock),
    .lineRxPositive(lineRxPositive),
    .lineRxNegative(lineRxNegative),
    .edgeSelect(rxOutCtrl_q[`FFC_B_LINE_EDGE]),
    .sampleValid_q(sampleValid),
    .samplePos_q(samplePos),
    .sampleNeg_q(sampleNeg),
    .edgeSeen_q()
  );

  // Decoded mark: either rail marks a one; violations are not carried
  assign decodedBit = samplePos | sampleNeg;

  // ==========================================
  // Loopbacks; switching happens immediately, so a few bits may glitch
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txLoopData <= 1'b0;
      txLoopValid <= 1'b0;
      txLineLoopPos <= 1'b0;
      txLineLoopNeg <= 1'b0;
      txLineLoopValid <= 1'b0;
      linePos_q <= 1'b0;
      lineNeg_q <= 1'b0;
      lineVal_q <= 1'b0;
    end else begin
      txLoopValid <= loopCtrl_q[`FFC_B_PAYLOAD_LOOP] & recoveredValid;
      txLoopData <= recoveredData;
      lineVal_q <= loopCtrl_q[`FFC_B_LINE_LOOP] & sampleValid;
      linePos_q <= decodedBit;
      lineNeg_q <= 1'b0;
      txLineLoopValid <= lineVal_q;
      txLineLoopPos <= linePos_q;
      txLineLoopNeg <= lineNeg_q;
    end
  end

  // ==========================================
  // Alarm-code interrupt gating
  assign singleMode = loopCtrl_q[`FFC_B_SINGLE];
  assign irqAny =
    (loopCtrl_q[`FFC_B_TX_IRQ] & (singleMode ? farAlarmTxDone : farAlarmTxTenDone)) |
    (loopCtrl_q[`FFC_B_STACK_IRQ] & farAlarmStackNotEmpty) |
    (loopCtrl_q[`FFC_B_IDLE_IRQ] & farAlarmIdleStart) |
    (loopCtrl_q[`FFC_B_RX_IRQ] & (singleMode ? farAlarmRxCode : farAlarmRxTenCode));

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shared_irq_out_n <= 1'b1;
    end else begin
      shared_irq_out_n <= ~irqAny;
    end
  end

  // ==========================================
  // MA byte fields
  assign g832 = (frameMode == `FFC_MODE_G832);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      maBit8 <= 1'b0;
      maBits67 <= 2'b00;
      maBits67Drive <= 1'b0;
    end else if (frameStart) begin
      if (!g832) begin
        maBit8 <= 1'b0;
        maBits67 <= 2'b00;
        maBits67Drive <= 1'b0;
      end else if (maCtrl_q[`FFC_B_SSM_EN]) begin
        // MI 00 picks bit 5, 01 bit 4, 10 bit 3, 11 bit 2
        maBit8 <= maCtrl_q[`FFC_B_SSM1 - multiframeIndicator];
        maBits67 <= multiframeIndicator;
        maBits67Drive <= 1'b1;
      end else begin
        maBit8 <= maCtrl_q[`FFC_B_SSM1];
        maBits67 <= {maCtrl_q[`FFC_B_PD1], maCtrl_q[`FFC_B_PD2]};
        maBits67Drive <= ~extCtrl_q[`FFC_B_EXT_PD];
      end
    end
  end

  // ==========================================
  // Receive system output substitution
  assign faultAuto = lossOfSignal | outOfFrame | alarmIndication |
                     ((frameMode == `FFC_MODE_DS3) & idleDetected);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxSystemDataOut <= 1'b0;
      aisPhase_q <= 2'b00;
    end else if (recoveredValid) begin
      // DS3 AIS is framed 1010; E3 AIS is all ones
      aisPhase_q <= aisPhase_q + 2'd1;
      if (rxOutCtrl_q[`FFC_B_RX_ONES]) begin
        rxSystemDataOut <= 1'b1;
      end else if (rxOutCtrl_q[`FFC_B_RX_AIS]) begin
        rxSystemDataOut <= (frameMode == `FFC_MODE_DS3) ? ~aisPhase_q[0] : 1'b1;
      end else if (rxOutCtrl_q[`FFC_B_AUTO_ONES] & faultAuto) begin
        rxSystemDataOut <= 1'b1;
      end else begin
        rxSystemDataOut <= recoveredData;
      end
    end
  end

  // ==========================================
  // System clocks: rise on data change, gaps low, inverted on request
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxGappedClockOut <= 1'b0;
      rxExtractClockOut <= 1'b0;
    end else begin
      rxGappedClockOut <= (recoveredValid & ~recoveredGap) ^
                          rxOutCtrl_q[`FFC_B_RX_CLK_INV];
      rxExtractClockOut <= (recoveredValid & recoveredGap) ^
                           rxOutCtrl_q[`FFC_B_RX_CLK_INV];
    end
  end

  // ==========================================
  // Reframe control; status detection is left untouched by substitution
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reframeStopOld_q <= 1'b0;
      frameSearchEn <= 1'b0;
      frameSlipOne <= 1'b0;
    end else begin
      reframeStopOld_q <= rxOutCtrl_q[`FFC_B_REFRAME_STOP];
      frameSearchEn <= ~rxOutCtrl_q[`FFC_B_REFRAME_STOP] & outOfFrame;
      frameSlipOne <= reframeStopOld_q & ~rxOutCtrl_q[`FFC_B_REFRAME_STOP];
    end
  end

endmodule
`default_nettype wire

/* testbench/ffc_feature_ctrl_properties.sv */
// Port-level assertions for the feature control bank
`timescale 1ns/1ps
`default_nettype none
`include "ffc_defines.vh"
module ffc_feature_ctrl_properties #(
  parameter LOOP_QUIET = `FFC_LOOP_QUIET
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] frameMode,
  input wire logic outOfFrame,
  input wire logic frameStart,
  input wire logic recoveredValid,
  input wire logic rxSystemDataOut,
  input wire logic txLineLoopNeg,
  input wire logic maBit8,
  input wire logic [1:0] maBits67,
  input wire logic frameSearchEn,
  input wire logic frameSlipOne,
  input wire logic loopQuiet
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Checks
  chk_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_ma_mode: assert property ((frameStart && frameMode != `FFC_MODE_G832) |=>
    (!maBit8 && maBits67 == 2'b00)) else $error("MA bits outside G832");
  chk_ma_hold: assert property ((!frameStart && $stable(frameMode)) |=>
    ($stable(maBit8) && $stable(maBits67))) else $error("MA bits moved between frames");
  chk_search_gate: assert property (!outOfFrame |=> !frameSearchEn)
    else $error("search without out of frame");
  chk_line_neg: assert property (txLineLoopNeg == 1'b0)
    else $error("violation kept in line loop");
  chk_data_hold: assert property (!recoveredValid |=> $stable(rxSystemDataOut))
    else $error("system data moved without a bit");
  chk_slip_single: assert property (frameSlipOne |=> !frameSlipOne)
    else $error("slip longer than one cycle");
  chk_quiet_span: assert property ($rose(loopQuiet) |-> loopQuiet [*8])
    else $error("quiet window too short");
endmodule
bind ffc_feature_ctrl ffc_feature_ctrl_properties #(.LOOP_QUIET(LOOP_QUIET)) ffc_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .hrdata(hrdata), .frameMode(frameMode),
  .outOfFrame(outOfFrame), .frameStart(frameStart), .recoveredValid(recoveredValid),
  .rxSystemDataOut(rxSystemDataOut), .txLineLoopNeg(txLineLoopNeg), .maBit8(maBit8),
  .maBits67(maBits67), .frameSearchEn(frameSearchEn), .frameSlipOne(frameSlipOne),
  .loopQuiet(loopQuiet));
`default_nettype wire

/* testbench/ffc_liu_model.sv */
// Line interface unit model driving the receive line pins
`timescale 1ns/1ps
`default_nettype none
module ffc_liu_model (
  input wire logic run,
  input wire logic sampleFalling,
  input wire logic [7:0] pattern,
  output logic lineClk,
  output logic linePos,
  output logic lineNeg
);
  initial begin
    lineClk = 1'b0;
    linePos = 1'b1;
    lineNeg = 1'b1;
  end
  task automatic launch(input int i);
    linePos = pattern[i];
    lineNeg = 1'b0;
  endtask
  // Clock stands still between frames; released pins flip so stale bits never look valid
  always begin
    wait (run === 1'b1);
    #3;
    for (int i = 7; i >= 0; i--) begin
      if (!sampleFalling) launch(i);
      #100;
      lineClk = 1'b1;
      if (sampleFalling) launch(i);
      #100;
      lineClk = 1'b0;
    end
    #100;
    linePos = ~linePos;
    lineNeg = ~lineNeg;
    wait (run === 1'b0);
  end
endmodule
`default_nettype wire

/* testbench/test_ffc_feature_ctrl.sv */
// Self-checking bench for the feature control bank
`timescale 1ns/1ps
`default_nettype none
`include "ffc_defines.vh"
module test_ffc_feature_ctrl;
  logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, oof = 1'b0, los = 1'b0;
  logic idle = 1'b0, fs = 1'b0, rv = 1'b0, rdat = 1'b0, ais = 1'b0, run = 1'b0, fall = 1'b0;
  logic gap = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, mode = 2'h0, mi = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [5:0] ev = 6'h00;
  logic [31:0] hwdata = 32'h0000_0000, rd;
  wire logic rdy, resp, irqN, sysData, loopData, loopValid, linePos, lineValid, ma8, maDrv;
  wire logic searchEn, slipOne, rxClk, rxPos, rxNeg, gck, xck;
  wire logic [31:0] hrdata;
  wire logic [1:0] ma67;
  int n_mismatch = 0, checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  ffc_feature_ctrl ffc_feature_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata(hrdata), .frameMode(mode),
    .outOfFrame(oof), .lossOfSignal(los), .alarmIndication(ais), .idleDetected(idle),
    .multiframeIndicator(mi), .frameStart(fs), .recoveredValid(rv), .recoveredData(rdat),
    .recoveredGap(gap), .farAlarmTxDone(ev[0]), .farAlarmTxTenDone(ev[1]),
    .farAlarmStackNotEmpty(ev[2]), .farAlarmIdleStart(ev[3]), .farAlarmRxCode(ev[4]),
    .farAlarmRxTenCode(ev[5]), .lineRxClock(rxClk), .lineRxPositive(rxPos),
    .lineRxNegative(rxNeg), .shared_irq_out_n(irqN), .rxSystemDataOut(sysData),
    .rxGappedClockOut(gck), .rxExtractClockOut(xck), .txLoopData(loopData),
    .txLoopValid(loopValid),
    .txLineLoopPos(linePos), .txLineLoopNeg(), .txLineLoopValid(lineValid), .maBit8(ma8),
    .maBits67(ma67), .maBits67Drive(maDrv), .frameSearchEn(searchEn),
    .frameSlipOne(slipOne), .loopQuiet());
  ffc_liu_model ffc_liu_model_inst (.run(run), .sampleFalling(fall), .pattern(8'hB4),
    .lineClk(rxClk), .linePos(rxPos), .lineNeg(rxNeg));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {a[5:0], 2'b00};
    hwrite <= w;
    @(posedge clk_sys);
    while (rdy !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    while (rdy !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  task automatic send_bit(input logic d, output logic q);
    @(posedge clk_sys);
    rdat <= d;
    rv <= 1'b1;
    @(posedge clk_sys);
    rv <= 1'b0;
    @(posedge clk_sys);
    #1 q = sysData;
  endtask
  task automatic frame(input logic [1:0] m);
    @(posedge clk_sys);
    mi <= m;
    fs <= 1'b1;
    @(posedge clk_sys);
    fs <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [23:0] t [5] = '{24'h26_0000, 24'h26_3F37, 24'h27_FF7F, 24'h28_0400, 24'h30_FF00};
    for (int i = 0; i < 5; i++) begin
      if (i > 0) ahb(1'b1, t[i][23:16], t[i][15:8]);
      ahb(1'b0, t[i][23:16], 8'h00);
      check(rd, {24'h00_0000, t[i][7:0]}, "register");
    end
    check(32'(resp), 32'h0, "okay response");
  endtask
  task automatic t_subst();
    logic [15:0] c [11] = '{16'h10_03, 16'h20_43, 16'h20_01, 16'h30_03, 16'h80_63,
      16'h80_13, 16'h80_52, 16'hA0_21, 16'h00_22, 16'h80_4B, 16'h80_07};
    logic b0, b1;
    for (int i = 0; i < 11; i++) begin
      mode <= c[i][7:6];
      los <= c[i][5];
      idle <= c[i][4];
      ais <= c[i][3];
      oof <= c[i][2];
      ahb(1'b1, 8'h28, c[i][15:8]);
      send_bit(1'b1, b0);
      send_bit(1'b0, b1);
      if (c[i][1:0] == 2'b01) check(32'(b0 ^ b1), 32'h1, "ais");
      else check(32'({b0, b1}), 32'(c[i][1:0]), "rx data");
    end
    ahb(1'b1, 8'h28, 8'h00);
    los <= 1'b0;
    idle <= 1'b0;
    ais <= 1'b0;
    oof <= 1'b0;
  endtask
  task automatic t_ma();
    logic [3:0] sync_status_msg = 4'hA;
    mode <= `FFC_MODE_G832;
    ahb(1'b1, 8'h27, 8'h68);
    for (int i = 0; i < 4; i++) begin
      frame(2'(i));
      check(32'(ma8), 32'(sync_status_msg[3 - i]), "ssm bit");
    end
    ahb(1'b1, 8'h27, 8'h22);
    for (int i = 0; i < 4; i++) begin
      frame(2'(i));
      check(32'({ma8, maDrv, ma67}), 32'hE, "tm pd");
    end
    ahb(1'b1, 8'h2C, 8'h01);
    frame(2'h1);
    check(32'({ma8, maDrv}), 32'h2, "ext pd");
    mode <= `FFC_MODE_G751;
    frame(2'h0);
    check(32'({ma8, ma67}), 32'h0, "not g832");
    ahb(1'b1, 8'h2C, 8'h00);
  endtask
  task automatic t_reframe();
    int hits;
    oof <= 1'b1;
    ahb(1'b1, 8'h28, 8'h40);
    repeat (3) @(posedge clk_sys);
    check(32'(searchEn), 32'h0, "stopped");
    ahb(1'b1, 8'h28, 8'h00);
    hits = 0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      #1 hits += int'(slipOne === 1'b1);
    end
    check(32'(hits), 32'h1, "slip");
    check(32'(searchEn), 32'h1, "resumed");
    oof <= 1'b0;
  endtask
  task automatic t_irq();
    logic [15:0] c [8] = '{16'h37_01, 16'h37_04, 16'h37_08, 16'h37_10, 16'h27_02,
      16'h27_20, 16'h00_3F, 16'h36_12};
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, 8'h26, c[i][15:8]);
      ev <= c[i][5:0];
      repeat (3) @(posedge clk_sys);
      #1 check(32'(irqN), 32'(i > 5), "irq");
      ev <= 6'h00;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  task automatic t_loops();
    logic [7:0] got;
    int n;
    ahb(1'b1, 8'h26, 8'h40);
    repeat (160) @(posedge clk_sys);
    for (int f = 0; f < 2; f++) begin
      ahb(1'b1, 8'h28, 8'(f));
      fall <= f[0];
      run <= 1'b1;
      n = 0;
      for (int k = 0; k < 600 && n < 8; k++) begin
        @(posedge clk_sys);
        #1 if (lineValid === 1'b1) begin
          got = {got[6:0], linePos};
          n++;
        end
      end
      run <= 1'b0;
      check(32'(got), 32'h0000_00B4, "line loop");
      repeat (40) @(posedge clk_sys);
    end
    ahb(1'b1, 8'h26, 8'h80);
    repeat (160) @(posedge clk_sys);
    @(posedge clk_sys);
    rdat <= 1'b1;
    rv <= 1'b1;
    @(posedge clk_sys);
    rv <= 1'b0;
    #1 check(32'({loopValid, loopData}), 32'h3, "payload loop");
    check(32'(sysData), 32'h1, "rx pins");
  endtask
  task automatic t_clocks();
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 8'h28, {6'h00, i[1], 1'b0});
      gap <= i[0];
      @(posedge clk_sys);
      rv <= 1'b1;
      @(posedge clk_sys);
      rv <= 1'b0;
      #1 check(32'({gck, xck}), 32'({~i[0], i[0]} ^ {2{i[1]}}), "bit clocks");
      @(posedge clk_sys);
      #1 check(32'({gck, xck}), 32'({2{i[1]}}), "idle clocks");
    end
    ahb(1'b1, 8'h28, 8'h00);
    gap <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_subst();
    t_ma();
    t_reframe();
    t_clocks();
    t_irq();
    t_loops();
    finish_test();
  end
endmodule
`default_nettype wire
